//--- shared/progctr_pkg.sv
// constants, register map and field layout of the program counter and return stack unit
package progctr_pkg;

    // counter and stack geometry
    localparam int PC_W       = 15;
    localparam int LOW_W      = 8;
    localparam int HIGH_W     = 7;
    localparam int PTR_W      = 5;
    localparam int DEPTH      = 16;
    localparam int IDX_W      = 4;
    localparam int CALL_OPD_W = 11;
    localparam int BRA_OPD_W  = 9;
    localparam int CALL_HI_LO = 3;

    // reset values and stack pointer limits
    localparam logic [PC_W-1:0]   PC_RESET     = 15'h0000;
    localparam logic [HIGH_W-1:0] LATCH_RESET  = 7'h00;
    localparam logic [PTR_W-1:0]  PTR_RESET    = 5'h1F;
    localparam logic [PTR_W-1:0]  PTR_FULL     = 5'h0F;
    localparam logic [PTR_W-1:0]  PTR_EMPTY    = 5'h1F;
    localparam logic [PC_W-1:0]   VECTOR_RESET = 15'h0004;

    // apb byte addresses, one aligned word per register
    localparam logic [7:0] ADDR_PC_LOW     = 8'h00;
    localparam logic [7:0] ADDR_PC_LATCH   = 8'h04;
    localparam logic [7:0] ADDR_STACK_LOW  = 8'h08;
    localparam logic [7:0] ADDR_STACK_HIGH = 8'h0C;
    localparam logic [7:0] ADDR_STACK_IDX  = 8'h10;
    localparam logic [7:0] ADDR_STACK_CTRL = 8'h14;

    // fields of the stack control and status word
    localparam int BIT_OVF      = 0;
    localparam int BIT_UNF      = 1;
    localparam int BIT_FAULT_EN = 2;

    // one core operation per instruction
    typedef enum logic [3:0] {
        OP_NONE,
        OP_FETCH,
        OP_WRITE_LOW,
        OP_ADD_LOW,
        OP_CALL_ABS,
        OP_CALL_IND,
        OP_BRANCH_ACC,
        OP_BRANCH_IMM,
        OP_RETURN,
        OP_RETURN_LIT,
        OP_RETURN_IRQ,
        OP_IRQ_VECTOR
    } core_op_t;

endpackage : progctr_pkg

//--- src/progctr_stack.sv
// program counter, high latch and 16-entry return stack with an apb register port
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/100ps

module progctr_stack #(
    parameter int STACK_DEPTH = progctr_pkg::DEPTH,
    parameter logic [progctr_pkg::PC_W-1:0] IRQ_VECTOR = progctr_pkg::VECTOR_RESET
) (
    // apb clock and reset
    input  wire logic                                pclk,
    input  wire logic                                presetn,
    // apb slave
    input  wire logic                                psel,
    input  wire logic                                penable,
    input  wire logic                                pwrite,
    input  wire logic [7:0]                          paddr,
    input  wire logic [31:0]                         pwdata,
    output logic      [31:0]                         prdata,
    output logic                                     pready,
    output logic                                     pslverr,
    // core operation request, one per cycle
    input  wire logic                                op_valid,
    input  wire progctr_pkg::core_op_t               op_code,
    input  wire logic [progctr_pkg::LOW_W-1:0]       op_acc,
    input  wire logic [progctr_pkg::LOW_W-1:0]       op_result,
    input  wire logic [progctr_pkg::CALL_OPD_W-1:0]  op_call_target,
    input  wire logic [progctr_pkg::BRA_OPD_W-1:0]   op_branch_offset,
    // fetch address and status toward the core
    output logic      [progctr_pkg::PC_W-1:0]        fetch_addr,
    output logic      [progctr_pkg::PTR_W-1:0]       stack_index_out,
    output logic                                     stack_overflow_flag,
    output logic                                     stack_underflow_flag,
    output logic                                     stack_reset_req
);

    ////////////////////////////////////////////////////////////////////////////////
    // geometry check

    // the pointer carries exactly one bit above the entry index
    generate
        if (STACK_DEPTH != progctr_pkg::DEPTH) begin : g_bad_depth
            $error("stack depth must equal the five-bit pointer range of sixteen");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    // counter step, wraps within the counter width
    function automatic logic [progctr_pkg::PC_W-1:0] pc_step(input logic [progctr_pkg::PC_W-1:0] pc);
        pc_step = progctr_pkg::PC_W'(pc + 15'h0001);
    endfunction : pc_step

    // entry selected by a pointer value; the top bit only marks over or under run
    function automatic logic [progctr_pkg::IDX_W-1:0] entry_of(input logic [progctr_pkg::PTR_W-1:0] ptr);
        entry_of = ptr[progctr_pkg::IDX_W-1:0];
    endfunction : entry_of

    ////////////////////////////////////////////////////////////////////////////////
    // state

    logic [progctr_pkg::PC_W-1:0]   pc;
    logic [progctr_pkg::HIGH_W-1:0] progctr_high_latch;
    logic [progctr_pkg::PTR_W-1:0]  stack_index;
    logic [progctr_pkg::PC_W-1:0]   stack_mem [progctr_pkg::DEPTH];
    logic                           stack_fault_reset_en;

    logic [progctr_pkg::PC_W-1:0]   next_pc;
    logic [progctr_pkg::PTR_W-1:0]  next_index;
    logic                           do_push;
    logic                           do_pop;
    logic [progctr_pkg::PC_W-1:0]   push_value;
    logic [progctr_pkg::PC_W-1:0]   pc_plus1;
    logic [progctr_pkg::PC_W-1:0]   stack_top;
    logic                           overflow_event;
    logic                           underflow_event;

    logic                           core_busy;
    logic                           apb_access;
    logic                           apb_wr;
    logic                           addr_mapped;
    logic [progctr_pkg::LOW_W-1:0]  progctr_low_byte;

    assign pc_plus1         = pc_step(pc);
    assign stack_top        = stack_mem[entry_of(stack_index)];
    assign progctr_low_byte = pc[progctr_pkg::LOW_W-1:0];
    assign fetch_addr       = pc;
    assign stack_index_out  = stack_index;

    ////////////////////////////////////////////////////////////////////////////////
    // apb handshake

    // the core owns the counter while it issues an operation; apb waits so no write is lost
    assign core_busy  = op_valid && (op_code != progctr_pkg::OP_NONE);
    assign pready     = !core_busy;
    assign apb_access = psel && penable && pready;
    assign apb_wr     = apb_access && pwrite;

    // decode of the six words
    always_comb begin
        case (paddr)
            progctr_pkg::ADDR_PC_LOW,
            progctr_pkg::ADDR_PC_LATCH,
            progctr_pkg::ADDR_STACK_LOW,
            progctr_pkg::ADDR_STACK_HIGH,
            progctr_pkg::ADDR_STACK_IDX,
            progctr_pkg::ADDR_STACK_CTRL: addr_mapped = 1'b1;
            default:                      addr_mapped = 1'b0;
        endcase
    end

    assign pslverr = apb_access && !addr_mapped;

    ////////////////////////////////////////////////////////////////////////////////
    // next counter and stack action

    // one operation per cycle; the decoder never issues two at once
    always_comb begin
        next_pc    = pc;
        do_push    = 1'b0;
        do_pop     = 1'b0;
        push_value = pc_plus1;
        if (op_valid) begin
            case (op_code)
                progctr_pkg::OP_FETCH: begin
                    next_pc = pc_plus1;
                end
                progctr_pkg::OP_WRITE_LOW: begin
                    next_pc = {progctr_high_latch, op_result};
                end
                progctr_pkg::OP_ADD_LOW: begin
                    // eight-bit sum: the carry is dropped, tables must not cross a block
                    next_pc = {progctr_high_latch, progctr_pkg::LOW_W'(pc[progctr_pkg::LOW_W-1:0] + op_acc)};
                end
                progctr_pkg::OP_CALL_ABS: begin
                    next_pc = {progctr_high_latch[progctr_pkg::HIGH_W-1:progctr_pkg::CALL_HI_LO],
                               op_call_target};
                    do_push = 1'b1;
                end
                progctr_pkg::OP_CALL_IND: begin
                    next_pc = {progctr_high_latch, op_acc};
                    do_push = 1'b1;
                end
                progctr_pkg::OP_BRANCH_ACC: begin
                    next_pc = progctr_pkg::PC_W'(pc_plus1 + {7'h00, op_acc});
                end
                progctr_pkg::OP_BRANCH_IMM: begin
                    next_pc = progctr_pkg::PC_W'(pc_plus1
                              + {{(progctr_pkg::PC_W-progctr_pkg::BRA_OPD_W){op_branch_offset[progctr_pkg::BRA_OPD_W-1]}},
                                 op_branch_offset});
                end
                progctr_pkg::OP_RETURN,
                progctr_pkg::OP_RETURN_LIT,
                progctr_pkg::OP_RETURN_IRQ: begin
                    next_pc = stack_top;
                    do_pop  = 1'b1;
                end
                progctr_pkg::OP_IRQ_VECTOR: begin
                    // the interrupted instruction has not run, so it is the return address
                    next_pc    = IRQ_VECTOR;
                    push_value = pc;
                    do_push    = 1'b1;
                end
                default: begin
                    next_pc = pc;
                end
            endcase
        end
    end

    // pointer steps: up before the push write, down after the pop read
    always_comb begin
        if (do_push) begin
            next_index = progctr_pkg::PTR_W'(stack_index + 5'h01);
        end else if (do_pop) begin
            next_index = progctr_pkg::PTR_W'(stack_index - 5'h01);
        end else begin
            next_index = stack_index;
        end
    end

    // a push from a full stack or a pop from an empty one
    assign overflow_event  = do_push && (stack_index == progctr_pkg::PTR_FULL);
    assign underflow_event = do_pop && (stack_index == progctr_pkg::PTR_EMPTY);

    ////////////////////////////////////////////////////////////////////////////////
    // program counter

    // core loads first; software low-byte writes only land while the core is idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc <= progctr_pkg::PC_RESET;
        end else if (core_busy) begin
            pc <= next_pc;
        end else if (apb_wr && paddr == progctr_pkg::ADDR_PC_LOW) begin
            pc <= {progctr_high_latch, pwdata[progctr_pkg::LOW_W-1:0]};
        end
    end

    // high latch: software only, no stack action touches it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            progctr_high_latch <= progctr_pkg::LATCH_RESET;
        end else if (apb_wr && paddr == progctr_pkg::ADDR_PC_LATCH) begin
            progctr_high_latch <= pwdata[progctr_pkg::HIGH_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // stack pointer and entries

    // pointer, moved by the core or set by software to reach any entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_index <= progctr_pkg::PTR_RESET;
        end else if (core_busy) begin
            stack_index <= next_index;
        end else if (apb_wr && paddr == progctr_pkg::ADDR_STACK_IDX) begin
            stack_index <= pwdata[progctr_pkg::PTR_W-1:0];
        end
    end

    // entries: no reset, the index wraps so a seventeenth push reuses entry zero
    always_ff @(posedge pclk) begin
        if (core_busy && do_push) begin
            stack_mem[entry_of(next_index)] <= push_value;
        end else if (apb_wr && paddr == progctr_pkg::ADDR_STACK_LOW) begin
            stack_mem[entry_of(stack_index)][progctr_pkg::LOW_W-1:0] <= pwdata[progctr_pkg::LOW_W-1:0];
        end else if (apb_wr && paddr == progctr_pkg::ADDR_STACK_HIGH) begin
            stack_mem[entry_of(stack_index)][progctr_pkg::PC_W-1:progctr_pkg::LOW_W] <=
                pwdata[progctr_pkg::HIGH_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // fault flags and reset request

    // sticky flags; a fresh event beats a software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_overflow_flag <= 1'b0;
        end else if (overflow_event) begin
            stack_overflow_flag <= 1'b1;
        end else if (apb_wr && paddr == progctr_pkg::ADDR_STACK_CTRL && !pwdata[progctr_pkg::BIT_OVF]) begin
            stack_overflow_flag <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_underflow_flag <= 1'b0;
        end else if (underflow_event) begin
            stack_underflow_flag <= 1'b1;
        end else if (apb_wr && paddr == progctr_pkg::ADDR_STACK_CTRL && !pwdata[progctr_pkg::BIT_UNF]) begin
            stack_underflow_flag <= 1'b0;
        end
    end

    // fault reset enable; clear by default so the stack wraps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_fault_reset_en <= 1'b0;
        end else if (apb_wr && paddr == progctr_pkg::ADDR_STACK_CTRL) begin
            stack_fault_reset_en <= pwdata[progctr_pkg::BIT_FAULT_EN];
        end
    end

    // one-cycle request to the reset logic, registered to keep it glitch free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_reset_req <= 1'b0;
        end else begin
            stack_reset_req <= stack_fault_reset_en && (overflow_event || underflow_event);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data

    // registered read data, captured at the edge that ends the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                progctr_pkg::ADDR_PC_LOW:     prdata <= {24'h00_0000, progctr_low_byte};
                progctr_pkg::ADDR_PC_LATCH:   prdata <= {25'h000_0000, progctr_high_latch};
                progctr_pkg::ADDR_STACK_LOW:  prdata <= {24'h00_0000, stack_top[progctr_pkg::LOW_W-1:0]};
                progctr_pkg::ADDR_STACK_HIGH: prdata <= {25'h000_0000, stack_top[progctr_pkg::PC_W-1:progctr_pkg::LOW_W]};
                progctr_pkg::ADDR_STACK_IDX:  prdata <= {27'h000_0000, stack_index};
                progctr_pkg::ADDR_STACK_CTRL: prdata <= {29'h0000_0000, stack_fault_reset_en,
                                                         stack_underflow_flag, stack_overflow_flag};
                default:                      prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule : progctr_stack

//--- test/progctr_stack_asserts.sv
// port assertions for the program counter and return stack unit
`timescale 1ns/100ps
module progctr_checks #(
    parameter logic [14:0] IRQ_VECTOR = 15'h0004
) (
    // clock and reset
    input wire logic                  pclk,
    input wire logic                  presetn,
    // core operation
    input wire logic                  op_valid,
    input wire progctr_pkg::core_op_t op_code,
    input wire logic [7:0]            op_acc,
    input wire logic [7:0]            op_result,
    input wire logic [10:0]           op_call_target,
    input wire logic [8:0]            op_branch_offset,
    // counter and stack state
    input wire logic [14:0]           fetch_addr,
    input wire logic [4:0]            stack_index_out,
    input wire logic                  stack_overflow_flag,
    input wire logic                  stack_underflow_flag,
    // apb handshake
    input wire logic                  pready
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    progctr_pkg::core_op_t op;
    logic                  push;
    logic                  pop;
    // idle cycles decode to none so the checks below test the code alone
    assign op   = op_valid ? op_code : progctr_pkg::OP_NONE;
    assign push = op inside {progctr_pkg::OP_CALL_ABS, progctr_pkg::OP_CALL_IND, progctr_pkg::OP_IRQ_VECTOR};
    assign pop  = op inside {progctr_pkg::OP_RETURN, progctr_pkg::OP_RETURN_LIT, progctr_pkg::OP_RETURN_IRQ};
    ////////////////////////////////////////
    reset_clear_a: assert property ($rose(presetn) |-> fetch_addr == 15'h0000)
        else $error("counter not clear after reset");
    fetch_step_a: assert property (op == progctr_pkg::OP_FETCH |=>
        fetch_addr == $past(fetch_addr) + 15'h0001) else $error("fetch did not step by one");
    low_write_a: assert property (op == progctr_pkg::OP_WRITE_LOW |=>
        fetch_addr[7:0] == $past(op_result)) else $error("low byte write lost");
    add_low_a: assert property (op == progctr_pkg::OP_ADD_LOW |=>
        fetch_addr[7:0] == 8'($past(fetch_addr)) + $past(op_acc)) else $error("computed jump sum wrong");
    call_abs_a: assert property (op == progctr_pkg::OP_CALL_ABS |=>
        fetch_addr[10:0] == $past(op_call_target)) else $error("absolute call target wrong");
    call_ind_a: assert property (op == progctr_pkg::OP_CALL_IND |=>
        fetch_addr[7:0] == $past(op_acc)) else $error("indirect call low byte wrong");
    branch_acc_a: assert property (op == progctr_pkg::OP_BRANCH_ACC |=>
        fetch_addr == $past(fetch_addr) + 15'h0001 + {7'h00, $past(op_acc)}) else $error("acc branch wrong");
    branch_imm_a: assert property (op == progctr_pkg::OP_BRANCH_IMM |=>
        fetch_addr == $past(fetch_addr) + 15'h0001 + 15'($signed($past(op_branch_offset))))
        else $error("imm branch wrong");
    push_index_a: assert property (push |=> stack_index_out == $past(stack_index_out) + 5'h01)
        else $error("push did not raise the pointer");
    pop_index_a: assert property (pop |=> stack_index_out == $past(stack_index_out) - 5'h01)
        else $error("pop did not lower the pointer");
    irq_entry_a: assert property (op == progctr_pkg::OP_IRQ_VECTOR |=> fetch_addr == IRQ_VECTOR)
        else $error("interrupt entry address wrong");
    overflow_flag_a: assert property (push && stack_index_out == 5'h0F |=> stack_overflow_flag)
        else $error("overflow flag not set");
    underflow_flag_a: assert property (pop && stack_index_out == 5'h1F |=> stack_underflow_flag)
        else $error("underflow flag not set");
    // software must be held off while the core loads the counter, or its write is lost
    op_stall_a: assert property (op != progctr_pkg::OP_NONE |-> !pready)
        else $error("apb not held off during a core op");
endmodule : progctr_checks

bind progctr_stack progctr_checks #(.IRQ_VECTOR(IRQ_VECTOR)) u_checks (
    .pclk(pclk), .presetn(presetn), .op_valid(op_valid), .op_code(op_code), .op_acc(op_acc),
    .op_result(op_result), .op_call_target(op_call_target), .op_branch_offset(op_branch_offset),
    .fetch_addr(fetch_addr), .stack_index_out(stack_index_out),
    .stack_overflow_flag(stack_overflow_flag), .stack_underflow_flag(stack_underflow_flag),
    .pready(pready)
);

//--- test/core_model.sv
// stand-in for the core decoder, issues one operation per call
`timescale 1ns/100ps
module core_model (
    // clock
    input wire logic              pclk,
    // operation toward the counter unit
    output progctr_pkg::core_op_t op_code,
    output logic                  op_valid,
    output logic [7:0]            op_acc,
    output logic [7:0]            op_result,
    output logic [10:0]           op_call_target,
    output logic [8:0]            op_branch_offset
);
    // idle from time zero
    initial begin
        op_valid = 1'b0;
        op_code = progctr_pkg::OP_NONE;
        op_acc = 8'h00;
        op_result = 8'h00;
        op_call_target = 11'h000;
        op_branch_offset = 9'h000;
    end
    ////////////////////////////////////////
    // one op for one cycle; operands flip afterwards so a stale value never looks live
    task automatic issue(input progctr_pkg::core_op_t op, input logic [10:0] v, input logic [8:0] b);
        @(posedge pclk);
        op_valid <= 1'b1;
        op_code <= op;
        op_acc <= v[7:0];
        op_result <= v[7:0];
        op_call_target <= v;
        op_branch_offset <= b;
        @(posedge pclk);
        op_valid <= 1'b0; // no op is issued while software moves the pointer
        op_code <= progctr_pkg::OP_NONE;
        op_acc <= ~v[7:0];
        op_result <= ~v[7:0];
        op_call_target <= ~v;
        op_branch_offset <= ~b;
    endtask : issue
endmodule : core_model

//--- test/program_counter_and_call_stack_test.sv
// self-checking bench for the program counter and return stack unit
`timescale 1ns/100ps
module program_counter_and_call_stack_test;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
    logic op_valid, ovf, unf, reset_req;
    logic [7:0] paddr, op_acc, op_result;
    logic [31:0] pwdata, prdata, r;
    logic [10:0] op_call_target;
    logic [8:0] op_branch_offset;
    logic [14:0] fetch_addr;
    logic [4:0] stack_index_out;
    progctr_pkg::core_op_t op_code;
    int failures, check_count, n;

    progctr_stack u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .op_valid(op_valid), .op_code(op_code), .op_acc(op_acc), .op_result(op_result),
        .op_call_target(op_call_target), .op_branch_offset(op_branch_offset), .fetch_addr(fetch_addr),
        .stack_index_out(stack_index_out), .stack_overflow_flag(ovf), .stack_underflow_flag(unf),
        .stack_reset_req(reset_req));
    core_model u_core (.pclk(pclk), .op_code(op_code), .op_valid(op_valid), .op_acc(op_acc),
        .op_result(op_result), .op_call_target(op_call_target), .op_branch_offset(op_branch_offset));
    ////////////////////////////////////////
    // 25 ns period
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic stop_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    // one apb transfer; request held until pready is seen at an edge, bounded so a hang ends the run
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            failures++;
            stop_test();
        end
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask : apb

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, r, exp);
    endtask : rd

    // outputs are looked at on the falling edge, clear of the launching edge
    task automatic op(input progctr_pkg::core_op_t o, input logic [10:0] v, input logic [8:0] b,
                      input logic [14:0] exp);
        u_core.issue(o, v, b);
        @(negedge pclk);
        chk("fetch_addr", fetch_addr, exp);
    endtask : op
    ////////////////////////////////////////
    initial begin
        failures = 0;
        check_count = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk("fetch_addr", fetch_addr, 32'h0000_0000);
        rd("index", progctr_pkg::ADDR_STACK_IDX, 32'h0000_001F);
        rd("ctrl", progctr_pkg::ADDR_STACK_CTRL, 32'h0000_0000);
        apb(1'b1, progctr_pkg::ADDR_PC_LATCH, 32'h0000_0055);
        apb(1'b1, progctr_pkg::ADDR_PC_LOW, 32'h0000_0012);
        chk("fetch_addr", fetch_addr, 32'h0000_5512);
        rd("pc_low", progctr_pkg::ADDR_PC_LOW, 32'h0000_0012);
        op(progctr_pkg::OP_FETCH, 11'h000, 9'h000, 15'h5513);
        op(progctr_pkg::OP_WRITE_LOW, 11'h0F0, 9'h000, 15'h55F0);
        op(progctr_pkg::OP_ADD_LOW, 11'h020, 9'h000, 15'h5510);
        op(progctr_pkg::OP_BRANCH_ACC, 11'h0F0, 9'h000, 15'h5601);
        op(progctr_pkg::OP_BRANCH_IMM, 11'h000, 9'h1F0, 15'h55F2);
        op(progctr_pkg::OP_CALL_ABS, 11'h7AB, 9'h000, 15'h57AB);
        rd("top_low", progctr_pkg::ADDR_STACK_LOW, 32'h0000_00F3);
        rd("top_high", progctr_pkg::ADDR_STACK_HIGH, 32'h0000_0055);
        op(progctr_pkg::OP_CALL_IND, 11'h03C, 9'h000, 15'h553C);
        op(progctr_pkg::OP_IRQ_VECTOR, 11'h000, 9'h000, 15'h0004);
        op(progctr_pkg::OP_RETURN_IRQ, 11'h000, 9'h000, 15'h553C);
        op(progctr_pkg::OP_RETURN_LIT, 11'h000, 9'h000, 15'h57AC);
        op(progctr_pkg::OP_RETURN, 11'h000, 9'h000, 15'h55F3);
        rd("latch", progctr_pkg::ADDR_PC_LATCH, 32'h0000_0055);
        // a pop from the empty stack takes what software planted at the top
        apb(1'b1, progctr_pkg::ADDR_STACK_LOW, 32'h0000_0034);
        apb(1'b1, progctr_pkg::ADDR_STACK_HIGH, 32'h0000_0012);
        op(progctr_pkg::OP_RETURN, 11'h000, 9'h000, 15'h1234);
        chk("underflow", unf, 32'h0000_0001);
        chk("index_out", stack_index_out, 32'h0000_001E);
        apb(1'b1, progctr_pkg::ADDR_STACK_CTRL, 32'h0000_0000);
        apb(1'b1, progctr_pkg::ADDR_STACK_IDX, 32'h0000_001F);
        for (int k = 0; k < 17; k++) begin
            op(progctr_pkg::OP_CALL_IND, 11'(k), 9'h000, 15'h5500 + 15'(k));
        end
        chk("overflow", ovf, 32'h0000_0001);
        chk("reset_req", reset_req, 32'h0000_0000);
        apb(1'b1, progctr_pkg::ADDR_STACK_IDX, 32'h0000_0000);
        rd("wrapped", progctr_pkg::ADDR_STACK_LOW, 32'h0000_0010);
        apb(1'b1, progctr_pkg::ADDR_STACK_IDX, 32'h0000_0001);
        rd("second", progctr_pkg::ADDR_STACK_LOW, 32'h0000_0001);
        apb(1'b1, progctr_pkg::ADDR_STACK_CTRL, 32'h0000_0004);
        apb(1'b1, progctr_pkg::ADDR_STACK_IDX, 32'h0000_000F);
        op(progctr_pkg::OP_CALL_IND, 11'h077, 9'h000, 15'h5577);
        n = 0;
        while (reset_req !== 1'b1 && n < 4) begin
            @(negedge pclk);
            n++;
        end
        chk("reset_req", reset_req, 32'h0000_0001);
        rd("unmapped", 8'h18, 32'h0000_0000);
        chk("pslverr", last_err, 32'h0000_0001);
        // a core op in the access phase stalls the write, which still lands afterwards
        fork
            apb(1'b1, progctr_pkg::ADDR_PC_LOW, 32'h0000_0066);
            begin
                @(posedge pclk);
                u_core.issue(progctr_pkg::OP_FETCH, 11'h000, 9'h000);
            end
        join
        chk("stalled_write", fetch_addr, 32'h0000_5566);
        // a second reset in mid-run clears the counter and the pointer again
        @(posedge pclk);
        presetn <= 1'b0;
        @(negedge pclk);
        chk("fetch_addr", fetch_addr, 32'h0000_0000);
        chk("index_out", stack_index_out, 32'h0000_001F);
        @(posedge pclk);
        presetn <= 1'b1;
        rd("pc_low", progctr_pkg::ADDR_PC_LOW, 32'h0000_0000);
        stop_test();
    end
endmodule : program_counter_and_call_stack_test
